// [otph_ctrl.v]
// Purpose: APB-controlled host that drives OTP operations on a NAND device
// Assumes: Device pins synchronous to i_sys_clk; one outstanding operation
// Notes:   Software loads ADDR, writes CTRL with GO, polls STATUS
`include "otph_defines.vh"
`default_nettype none

module otph_ctrl (
  input  wire        i_sys_clk,
  input  wire        i_nrst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire        i_ready_busy_n,
  input  wire [7:0]  i_io_in,
  output wire [7:0]  o_io_out,
  output wire        o_io_oe,
  output wire        o_cle,
  output wire        o_ale,
  output wire        o_we_n,
  output wire        o_read_enable_n,
  output wire        o_ce_n
);

  // ================================================================
  // Sequencer states
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_SEQ   = 4'h1;
  localparam [3:0] S_WAITB = 4'h2;
  localparam [3:0] S_BUSY  = 4'h3;
  localparam [3:0] S_STAT  = 4'h4;
  localparam [3:0] S_SREAD = 4'h5;
  localparam [3:0] S_BACK  = 4'h6;
  localparam [3:0] S_DONE  = 4'h7;

  reg [3:0]  state_ff;
  reg [2:0]  op_ff;
  reg [3:0]  step_ff;
  reg [7:0]  page_ff;
  reg [11:0] col_ff;
  reg [7:0]  status_ff;
  reg [7:0]  rdata_ff;
  reg        prot_mode_ff;
  reg        otp_mode_ff;
  reg        protected_ff;
  reg        range_err_ff;
  reg        issued_ff;
  reg [7:0]  wait_ff;
  reg [15:0] count_ff;

  reg        st_start;
  reg [1:0]  st_kind;
  reg [7:0]  st_byte;
  reg        seq_last;
  wire       st_busy;
  wire       st_done;
  wire [7:0] st_rbyte;

  otph_strobe u_strobe (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_start   (st_start),
    .i_kind    (st_kind),
    .i_byte    (st_byte),
    .i_io_in   (i_io_in),
    .o_busy    (st_busy),
    .o_done    (st_done),
    .o_rbyte   (st_rbyte),
    .o_cle     (o_cle),
    .o_ale     (o_ale),
    .o_we_n    (o_we_n),
    .o_re_n    (o_read_enable_n),
    .o_io_out  (o_io_out),
    .o_io_oe   (o_io_oe)
  );

  assign o_ce_n    = 1'b0;
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;

  wire busy_op = (state_ff != S_IDLE);
  wire wr_en   = i_psel & i_penable & i_pwrite;
  wire go      = wr_en & (i_paddr == `OTPH_REG_CTRL) & i_pwdata[`OTPH_CTRL_GO] & ~busy_op;
  wire [2:0] go_op = i_pwdata[`OTPH_CTRL_OP_MSB:`OTPH_CTRL_OP_LSB];
  // Pages outside the OTP window are never put on the bus by a read
  wire page_ok = (page_ff >= `OTPH_PAGE_MIN) && (page_ff <= `OTPH_PAGE_MAX); // R09

  // ================================================================
  // Cycle list of each operation: kind and byte per step
  always @* begin
    st_kind  = 2'h0;
    st_byte  = 8'h00;
    seq_last = 1'b0;
    case (op_ff)
      `OTPH_OP_ENTER, `OTPH_OP_PROT_MODE, `OTPH_OP_EXIT: begin
        case (step_ff) // R23
          4'h0: st_byte = `OTPH_CMD_SETFEAT;
          4'h1: begin
            st_kind = 2'h1;
            st_byte = `OTPH_FEAT_OTP;
          end
          4'h2: begin
            st_kind = 2'h2;
            st_byte = (op_ff == `OTPH_OP_ENTER) ? `OTPH_P1_OTP :
                      (op_ff == `OTPH_OP_PROT_MODE) ? `OTPH_P1_PROT : `OTPH_P1_EXIT;
          end
          default: begin
            st_kind  = 2'h2;
            st_byte  = 8'h00;
            seq_last = (step_ff == 4'h5);
          end
        endcase
      end
      `OTPH_OP_PROTECT: begin
        case (step_ff) // R02
          4'h0: st_byte = `OTPH_CMD_PROG;
          4'h1, 4'h2, 4'h3, 4'h4, 4'h5: st_kind = 2'h1;
          4'h6, 4'h7: st_kind = 2'h2; // R19 R20
          default: begin
            st_byte  = `OTPH_CMD_PROG_GO;
            seq_last = 1'b1;
          end
        endcase
      end
      `OTPH_OP_READ: begin
        case (step_ff) // R08 R10
          4'h0: st_byte = `OTPH_CMD_READ;
          4'h1: begin
            st_kind = 2'h1;
            st_byte = col_ff[7:0];
          end
          4'h2: begin
            st_kind = 2'h1;
            st_byte = {4'h0, col_ff[11:8]};
          end
          4'h3: begin
            st_kind = 2'h1;
            st_byte = page_ff;
          end
          4'h4, 4'h5: st_kind = 2'h1;
          default: begin
            st_byte  = `OTPH_CMD_READ_GO;
            seq_last = 1'b1;
          end
        endcase
      end
      `OTPH_OP_COLUMN: begin
        case (step_ff) // R12
          4'h0: st_byte = `OTPH_CMD_RCOL;
          4'h1: begin
            st_kind = 2'h1;
            st_byte = col_ff[7:0];
          end
          4'h2: begin
            st_kind = 2'h1;
            st_byte = {4'h0, col_ff[11:8]};
          end
          default: begin
            st_byte  = `OTPH_CMD_RCOL_GO;
            seq_last = 1'b1;
          end
        endcase
      end
      default: begin
        st_kind  = 2'h3; // R13
        seq_last = 1'b1;
      end
    endcase
    // Status poll and return to data output override the op's cycle list
    case (state_ff)
      S_STAT: begin
        st_kind = 2'h0;
        st_byte = `OTPH_CMD_STATUS; // R04
      end
      S_SREAD: begin
        st_kind = 2'h3;
        st_byte = 8'h00;
      end
      S_BACK: begin
        st_kind = 2'h0;
        st_byte = `OTPH_CMD_READ; // R18
      end
      default: begin
      end
    endcase
  end

  // ================================================================
  // Sequencer
  always @* begin
    st_start = 1'b0;
    case (state_ff)
      S_SEQ:   st_start = ~st_busy & ~st_done & ~issued_ff;
      S_STAT:  st_start = ~st_busy & ~st_done & ~issued_ff;
      S_SREAD: st_start = ~st_busy & ~st_done & ~issued_ff;
      S_BACK:  st_start = ~st_busy & ~st_done & ~issued_ff;
      default: st_start = 1'b0;
    endcase
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff     <= S_IDLE;
      op_ff        <= 3'h0;
      step_ff      <= 4'h0;
      page_ff      <= `OTPH_PAGE_MIN;
      col_ff       <= 12'h000;
      status_ff    <= 8'h00;
      rdata_ff     <= 8'h00;
      prot_mode_ff <= 1'b0;
      otp_mode_ff  <= 1'b0;
      protected_ff <= 1'b0;
      range_err_ff <= 1'b0;
      issued_ff    <= 1'b0;
      wait_ff      <= 8'h00;
      count_ff     <= 16'h0000;
    end else begin
      if (st_start) begin
        issued_ff <= 1'b1;
      end else if (st_done) begin
        issued_ff <= 1'b0;
      end
      if (wr_en && (i_paddr == `OTPH_REG_ADDR) && !busy_op) begin
        col_ff  <= i_pwdata[11:0];
        page_ff <= i_pwdata[23:16];
      end
      case (state_ff)
        S_IDLE: begin
          if (go) begin
            op_ff        <= go_op;
            step_ff      <= 4'h0;
            range_err_ff <= 1'b0;
            if ((go_op == `OTPH_OP_READ) && !page_ok) begin
              range_err_ff <= 1'b1; // R09
            end else if ((go_op == `OTPH_OP_PROTECT) && !prot_mode_ff) begin
              range_err_ff <= 1'b1;
            end else if (go_op != 3'h0) begin
              state_ff <= S_SEQ;
            end
          end
        end
        S_SEQ: begin
          if (st_done) begin
            step_ff <= step_ff + 4'h1;
            if (op_ff == `OTPH_OP_FETCH) begin
              rdata_ff <= st_rbyte;
              count_ff <= count_ff + 16'h0001;
            end
            if (seq_last) begin
              wait_ff <= 8'h00;
              if ((op_ff == `OTPH_OP_PROTECT) || (op_ff == `OTPH_OP_READ)) begin
                state_ff <= S_WAITB;
              end else begin
                state_ff <= S_DONE;
              end
            end
          end
        end
        S_WAITB: begin
          // Ready/busy falls only after the write-to-busy delay
          wait_ff <= wait_ff + 8'h01;
          if (wait_ff == (`OTPH_T_WB_CYC - 1)) begin
            state_ff <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (i_ready_busy_n) begin
            state_ff <= S_STAT; // R03 R11
          end
        end
        S_STAT: begin
          if (st_done) begin
            state_ff <= S_SREAD; // R04
          end
        end
        S_SREAD: begin
          if (st_done) begin
            status_ff <= st_rbyte; // R05 R17 R24
            // Polling again covers a status taken while still busy
            if (!st_rbyte[`OTPH_ST_RDY]) begin
              state_ff <= S_STAT; // R04
            end else if (op_ff == `OTPH_OP_READ) begin
              state_ff <= S_BACK;
            end else begin
              if (!st_rbyte[`OTPH_ST_FAIL]) begin
                protected_ff <= 1'b1; // R06 R01
              end
              state_ff <= S_DONE;
            end
          end
        end
        S_BACK: begin
          if (st_done) begin
            count_ff <= 16'h0000;
            state_ff <= S_DONE; // R18
          end
        end
        S_DONE: begin
          case (op_ff)
            `OTPH_OP_ENTER: begin
              otp_mode_ff  <= 1'b1;
              prot_mode_ff <= 1'b0;
            end
            `OTPH_OP_PROT_MODE: begin
              otp_mode_ff  <= 1'b0;
              prot_mode_ff <= 1'b1;
            end
            `OTPH_OP_EXIT: begin
              otp_mode_ff  <= 1'b0;
              prot_mode_ff <= 1'b0;
            end
            default: begin
              otp_mode_ff <= otp_mode_ff;
            end
          endcase
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // ================================================================
  // APB read mux; zero wait states, unmapped reads return zero
  always @* begin
    case (i_paddr)
      `OTPH_REG_CTRL:   o_prdata = {28'h0000000, 1'b0, op_ff};
      `OTPH_REG_ADDR:   o_prdata = {8'h00, page_ff, 4'h0, col_ff};
      `OTPH_REG_STATUS: o_prdata = {16'h0000, status_ff, 2'h0, range_err_ff,
                                    protected_ff, prot_mode_ff, otp_mode_ff,
                                    i_ready_busy_n, busy_op};
      `OTPH_REG_RDATA:  o_prdata = {24'h000000, rdata_ff};
      `OTPH_REG_COUNT:  o_prdata = {16'h0000, count_ff};
      default:          o_prdata = 32'h00000000;
    endcase
  end

endmodule

`default_nettype wire

// [otph_defines.vh]
// Purpose: Constants for the OTP page access host controller
// Assumes: 100 MHz i_sys_clk, asynchronous NAND device on the far side
// Notes:   Offsets are byte addresses on the APB register port
//
// What the document says
// R01: Device refuses OTP programming forever once the area is protected.
// R02: Protect: command 80h, address cycles, two 00h data cycles, command 10h.
// R03: Program after protect does nothing; busy only for otp_busy_time.
// R04: In OTP mode status comes only by 70h; bit 5 mirrors ready_busy_n.
// R05: When ready, status bit 0 tells pass or fail of the OTP operation.
// R06: Host treats the area protected only after passing status after protect.
// R07: OTP pages are readable whether protected or not.
// R08: OTP read: 00h, five address cycles, page 02h..1Fh, then 30h.
// R09: Host addresses only OTP pages 02h to 1Fh; the protect address cycles send page 00h.
// R10: No cached page read on OTP pages; plain read only.
// R11: Device is busy for array_read_time while loading the OTP page.
// R12: Random data output pair 05h/E0h changes column in the loaded page.
// R13: Only the loaded page is readable; each read_enable_n pulse gives next item.
// R14: ECC detects 9 and corrects 8 bit errors per codeword.
// R15: Device computes parity during program busy and stores it in spare.
// R16: On read device corrects 1 to 8 errors and outputs corrected data.
// R17: After ECC read, status bit 0 flags an uncorrectable page.
// R18: After polling status, host issues 00h before reading data.
// R19: Each user area in one partial program; at most four per page.
// R20: Host never writes the ECC parity region.
// R21: x8 map: main 000h-7FFh, meta 800h-83Fh, parity 840h-87Fh.
// R22: x16 map: eight main areas, meta 800h-83Fh, parity 840h-87Fh.
// R23: Set feature 90h with 01h enters OTP, 03h protect mode, 00h leaves.
// R24: ECC outcome in status bits 4, 3, 0 with the documented codes.
`ifndef OTPH_DEFINES_VH
`define OTPH_DEFINES_VH

// ==================================================================
// APB register offsets
`define OTPH_REG_CTRL      12'h000
`define OTPH_REG_ADDR      12'h004
`define OTPH_REG_STATUS    12'h008
`define OTPH_REG_RDATA     12'h00c
`define OTPH_REG_COUNT     12'h010

// ==================================================================
// Control fields
`define OTPH_CTRL_OP_LSB   0
`define OTPH_CTRL_OP_MSB   2
`define OTPH_CTRL_GO       31
`define OTPH_OP_ENTER      3'h1
`define OTPH_OP_PROT_MODE  3'h2
`define OTPH_OP_EXIT       3'h3
`define OTPH_OP_PROTECT    3'h4
`define OTPH_OP_READ       3'h5
`define OTPH_OP_COLUMN     3'h6
`define OTPH_OP_FETCH      3'h7

// ==================================================================
// NAND command codes
`define OTPH_CMD_SETFEAT   8'hef
`define OTPH_CMD_PROG      8'h80
`define OTPH_CMD_PROG_GO   8'h10
`define OTPH_CMD_READ      8'h00
`define OTPH_CMD_READ_GO   8'h30
`define OTPH_CMD_STATUS    8'h70
`define OTPH_CMD_RCOL      8'h05
`define OTPH_CMD_RCOL_GO   8'he0
`define OTPH_FEAT_OTP      8'h90
`define OTPH_P1_OTP        8'h01
`define OTPH_P1_PROT       8'h03
`define OTPH_P1_EXIT       8'h00
`define OTPH_PAGE_MIN      8'h02
`define OTPH_PAGE_MAX      8'h1f

// ==================================================================
// Status bits
`define OTPH_ST_FAIL       0
`define OTPH_ST_ECC_LO     3
`define OTPH_ST_ECC_HI     4
`define OTPH_ST_RDY        5

// ==================================================================
// Pin timing: strobe low/high time and write-to-busy delay in ns, and cycles at 10 ns
`define OTPH_CLK_NS        10
`define OTPH_T_STROBE_NS   20
`define OTPH_T_STROBE_CYC  ((`OTPH_T_STROBE_NS + `OTPH_CLK_NS - 1) / `OTPH_CLK_NS)
`define OTPH_T_WB_NS       100
`define OTPH_T_WB_CYC      ((`OTPH_T_WB_NS + `OTPH_CLK_NS - 1) / `OTPH_CLK_NS)

`endif

// [otph_strobe.v]
// Purpose: One NAND bus cycle: command, address, write data or read data
// Assumes: Strobe low and high time both OTPH_T_STROBE_CYC cycles
// Notes:   o_done pulses one cycle when the cycle has finished
`include "otph_defines.vh"
`default_nettype none

module otph_strobe (
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  input  wire       i_start,
  input  wire [1:0] i_kind,
  input  wire [7:0] i_byte,
  input  wire [7:0] i_io_in,
  output wire       o_busy,
  output reg        o_done,
  output reg  [7:0] o_rbyte,
  output reg        o_cle,
  output reg        o_ale,
  output reg        o_we_n,
  output reg        o_re_n,
  output reg  [7:0] o_io_out,
  output reg        o_io_oe
);

  // ================================================================
  // Kinds: 0 command, 1 address, 2 write data, 3 read data
  localparam [1:0] PH_IDLE = 2'h0;
  localparam [1:0] PH_LOW  = 2'h1;
  localparam [1:0] PH_HIGH = 2'h2;

  reg [1:0] phase_ff;
  reg [3:0] cnt_ff;
  reg       rd_ff;

  assign o_busy = (phase_ff != PH_IDLE);

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_ff <= PH_IDLE;
      cnt_ff   <= 4'h0;
      rd_ff    <= 1'b0;
      o_done   <= 1'b0;
      o_rbyte  <= 8'h00;
      o_cle    <= 1'b0;
      o_ale    <= 1'b0;
      o_we_n   <= 1'b1;
      o_re_n   <= 1'b1;
      o_io_out <= 8'h00;
      o_io_oe  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (phase_ff)
        PH_IDLE: begin
          if (i_start) begin
            rd_ff    <= (i_kind == 2'h3);
            o_cle    <= (i_kind == 2'h0);
            o_ale    <= (i_kind == 2'h1);
            o_io_out <= i_byte;
            o_io_oe  <= (i_kind != 2'h3);
            o_we_n   <= (i_kind == 2'h3);
            o_re_n   <= (i_kind != 2'h3); // R13
            cnt_ff   <= 4'h0;
            phase_ff <= PH_LOW;
          end
        end
        PH_LOW: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == (`OTPH_T_STROBE_CYC - 1)) begin
            // Read data is taken just before the rising strobe edge
            if (rd_ff) begin
              o_rbyte <= i_io_in;
            end
            o_we_n   <= 1'b1;
            o_re_n   <= 1'b1;
            cnt_ff   <= 4'h0;
            phase_ff <= PH_HIGH;
          end
        end
        PH_HIGH: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == (`OTPH_T_STROBE_CYC - 1)) begin
            o_cle    <= 1'b0;
            o_ale    <= 1'b0;
            o_io_oe  <= 1'b0;
            o_done   <= 1'b1;
            phase_ff <= PH_IDLE;
          end
        end
        default: begin
          phase_ff <= PH_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [otph_checker.sv]
// Purpose: Pin protocol checks on the OTP page access host controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound onto otph_ctrl below the module
`default_nettype none

module otph_checker (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       i_ready_busy_n,
  input wire logic [7:0] o_io_out,
  input wire logic       o_io_oe,
  input wire logic       o_cle,
  input wire logic       o_ale,
  input wire logic       o_we_n,
  input wire logic       o_read_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // ==================================================================
  // Strobe framing
  // Second low cycle, then at least two high cycles before the next edge
  sequence s_strobe(x);
    !x ##1 x[*2];
  endsequence
  sequence s_held;
    ($stable(o_io_out) && $stable(o_cle) && $stable(o_ale))[*2];
  endsequence
  property p_we_pulse;
    $fell(o_we_n) |=> s_strobe(o_we_n);
  endproperty
  property p_re_pulse;
    $fell(o_read_enable_n) |=> s_strobe(o_read_enable_n);
  endproperty
  property p_we_held;
    $fell(o_we_n) |=> s_held;
  endproperty
  property p_we_drives;
    $fell(o_we_n) && !o_cle && !o_ale |=> o_io_oe;
  endproperty
  property p_no_overlap;
    !(!o_we_n && !o_read_enable_n);
  endproperty
  property p_cle_ale;
    !(o_cle && o_ale);
  endproperty
  // Host must let go of IO while the device drives it
  property p_release;
    !o_read_enable_n |-> !o_io_oe;
  endproperty
  property p_cmd_ready;
    $fell(o_we_n) && o_cle |-> i_ready_busy_n;
  endproperty
  property p_re_ready;
    $fell(o_read_enable_n) |-> i_ready_busy_n;
  endproperty

  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
  a_re_pulse: assert property (p_re_pulse) else $error("read strobe width wrong");
  a_we_held: assert property (p_we_held) else $error("bus cycle moved under strobe");
  a_we_drives: assert property (p_we_drives) else $error("data cycle not driven");
  a_no_overlap: assert property (p_no_overlap) else $error("both strobes low");
  a_cle_ale: assert property (p_cle_ale) else $error("command and address latch");
  a_release: assert property (p_release) else $error("host drives during read");
  a_cmd_ready: assert property (p_cmd_ready) else $error("command while busy");
  a_re_ready: assert property (p_re_ready) else $error("read strobe while busy");
endmodule

bind otph_ctrl otph_checker u_otph_checker (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ready_busy_n(i_ready_busy_n),
  .o_io_out(o_io_out), .o_io_oe(o_io_oe), .o_cle(o_cle), .o_ale(o_ale),
  .o_we_n(o_we_n), .o_read_enable_n(o_read_enable_n));
`default_nettype wire

// [otph_nand_model.sv]
// Purpose: Behavioural NAND device answering OTP commands
// Assumes: Busy times counted on the bench clock
// Notes:   Page data is page number xor column; no bit errors
`default_nettype none

module otph_nand_model #(
  parameter int T_READ = 40,
  parameter int T_PROG = 60,
  parameter int T_OBSY = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic [7:0] i_io,
  output wire logic       o_rb,
  output var  logic [7:0] o_io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cmd_ff = 8'h00;
  logic [7:0]  pg_ff = 8'h00;
  logic [11:0] col_ff = 12'h000;
  int          acnt_ff = 0;
  int          dcnt_ff = 0;
  int          busy_ff = 0;
  logic        pmode_ff = 1'h0;
  logic        prot_ff = 1'h0;
  logic        stmode_ff = 1'h0;
  logic        fail_ff = 1'h0;

  logic        rb_ff = 1'h1;

  initial o_io = 8'h5a;
  // Ready/busy is a flop of the bench clock so the host never races it
  assign o_rb = rb_ff;
  always @(posedge i_clk) begin
    if (busy_ff > 0) busy_ff = busy_ff - 1;
    rb_ff <= (busy_ff == 0);
  end

  always @(posedge i_we_n) begin
    if (i_cle) begin
      cmd_ff = i_io;
      acnt_ff = 0;
      dcnt_ff = 0;
      if (i_io == 8'h70) stmode_ff = 1'h1;
      if (i_io == 8'h00) stmode_ff = 1'h0;
      // Only 30h loads a page, so a cached read never starts
      if (i_io == 8'h30) begin
        busy_ff = T_READ;
        fail_ff = 1'h0;
      end
      if (i_io == 8'h10) begin
        fail_ff = prot_ff;
        busy_ff = prot_ff ? T_OBSY : T_PROG;
        prot_ff = prot_ff | pmode_ff;
      end
    end else if (i_ale) begin
      if (acnt_ff == 0) col_ff[7:0] = i_io;
      if (acnt_ff == 1) col_ff[11:8] = i_io[3:0];
      if (acnt_ff == 2) pg_ff = i_io;
      acnt_ff++;
    end else begin
      if (cmd_ff == 8'hef && dcnt_ff == 0) pmode_ff = (i_io == 8'h03);
      dcnt_ff++;
    end
  end

  always @(negedge i_re_n) begin
    o_io = stmode_ff ? {1'h1, o_rb, o_rb, 4'h0, fail_ff} : pg_ff ^ col_ff[7:0];
  end
  always @(posedge i_re_n) begin
    if (!stmode_ff) col_ff++;
    // Released bus shows the inverse, so a late sample cannot pass
    o_io = ~o_io;
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the OTP page access host controller
// Assumes: APB master on a 100 MHz clock, model device on the pins
// Notes:   Every scenario is one task that judges its own results
`include "otph_defines.vh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic        rb, io_oe, cle, ale, we_n, re_n, ce_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  io_in, io_out;
  int          fails, cmp_count;

  otph_ctrl u_otph_ctrl (
    .i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ready_busy_n(rb), .i_io_in(io_in),
    .o_io_out(io_out), .o_io_oe(io_oe), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
    .o_read_enable_n(re_n), .o_ce_n(ce_n));
  otph_nand_model u_otph_nand_model (
    .i_clk(clk), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
    .i_io(io_out), .o_rb(rb), .o_io(io_in));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One idle edge between transfers keeps each signal to one write per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Start an operation and poll until it has finished; rd holds STATUS
  task automatic op(input logic [2:0] code);
    int n;
    apb(1'h1, `OTPH_REG_CTRL, {1'h1, 28'h0, code});
    n = 0;
    do begin
      apb(1'h0, `OTPH_REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 500);
    chk({7'h0, rd[0]}, 8'h00);
  endtask

  task automatic fetch(input logic [7:0] exp);
    op(`OTPH_OP_FETCH);
    apb(1'h0, `OTPH_REG_RDATA, 32'h0);
    chk(rd[7:0], exp);
  endtask

  task automatic t_read(input logic [7:0] pg);
    apb(1'h1, `OTPH_REG_ADDR, {8'h00, pg, 4'h0, 12'h005});
    op(`OTPH_OP_READ);
    chk(rd[15:8], 8'he0);
    chk({7'h0, rd[5]}, 8'h00);
    chk({7'h0, rd[1]}, 8'h01);
    fetch(pg ^ 8'h05);
    fetch(pg ^ 8'h06);
    apb(1'h0, `OTPH_REG_COUNT, 32'h0);
    chk(rd[7:0], 8'h02);
    apb(1'h1, `OTPH_REG_ADDR, {8'h00, pg, 4'h0, 12'h7ff});
    op(`OTPH_OP_COLUMN);
    fetch(pg ^ 8'hff);
    $display("test read page %h done", pg);
  endtask

  task automatic t_refuse;
    logic [7:0] bad [2];
    bad = '{8'h01, 8'h20};
    foreach (bad[i]) begin
      apb(1'h1, `OTPH_REG_ADDR, {8'h00, bad[i], 16'h0000});
      op(`OTPH_OP_READ);
      chk({7'h0, rd[5]}, 8'h01);
    end
    op(`OTPH_OP_PROTECT);
    chk({7'h0, rd[5]}, 8'h01);
    chk({7'h0, rd[4]}, 8'h00);
    $display("test refuse done");
  endtask

  task automatic t_protect;
    op(`OTPH_OP_EXIT);
    chk({6'h0, rd[3:2]}, 8'h00);
    op(`OTPH_OP_PROT_MODE);
    chk({7'h0, rd[3]}, 8'h01);
    op(`OTPH_OP_PROTECT);
    chk(rd[15:8], 8'he0);
    chk({7'h0, rd[4]}, 8'h01);
    op(`OTPH_OP_PROTECT);
    chk(rd[15:8], 8'he1);
    op(`OTPH_OP_EXIT);
    op(`OTPH_OP_ENTER);
    t_read(8'h03);
    $display("test protect done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test;
  end

  initial begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    op(`OTPH_OP_ENTER);
    chk({7'h0, rd[2]}, 8'h01);
    chk({6'h0, ce_n, pslverr}, 8'h00);
    t_read(8'h02);
    t_read(8'h1f);
    t_refuse;
    t_protect;
    finish_test;
  end
endmodule
`default_nettype wire
